// File: common/spq_pkg.sv
// shared constants and types of the stepper phase sequencer
`default_nettype none
package spq_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int RST_SETTLE_US    = 10;
    localparam int RST_SETTLE_CYC   = RST_SETTLE_US * CLK_MHZ;
    localparam int SETTLE_W         = 10;

    // ------------------------------------------------------------
    // synchronised pin bundle
    // ------------------------------------------------------------
    localparam int SYNC_W           = 10;
    localparam int PIN_STEP_CLK     = 0;
    localparam int PIN_DIR          = 1;
    localparam int PIN_ENABLE       = 2;
    localparam int PIN_MODE_A       = 3;
    localparam int PIN_MODE_B       = 4;
    localparam int PIN_EDGE_SEL     = 5;
    localparam int PIN_RESET_N      = 6;
    localparam int PIN_OPEN_TERM    = 7;
    localparam int PIN_OVER_CUR     = 8;
    localparam int PIN_OVER_HEAT    = 9;

    // ------------------------------------------------------------
    // phase position and drive pattern
    // ------------------------------------------------------------
    localparam int POS_W            = 5;
    localparam logic [4:0] POS_RESET = 5'h04;
    localparam logic [3:0] DRIVE_OFF = 4'h0;
    localparam logic [4:0] INC_TWO_PHASE = 5'h08;
    localparam logic [4:0] INC_ONE_TWO   = 5'h04;
    localparam logic [4:0] INC_W_ONE_TWO = 5'h02;
    localparam logic [4:0] INC_2W_ONE_TWO = 5'h01;

    // fault type codes shown on the fault type level output
    localparam logic [1:0] FTYPE_NONE = 2'h0;
    localparam logic [1:0] FTYPE_OPEN = 2'h1;
    localparam logic [1:0] FTYPE_OVERCUR = 2'h2;
    localparam logic [1:0] FTYPE_OVERHEAT = 2'h3;

    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam int ADDR_W           = 8;
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_STEPCNT = 8'h08;
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam int CTRL_CNTCLR_BIT  = 1;
    localparam logic CTRL_INHIBIT_RESET = 1'b0;
    localparam logic [15:0] STEPCNT_RESET = 16'h0000;

    typedef enum logic [2:0] {
        SPQ_RUN     = 3'b001,
        SPQ_HOLD    = 3'b010,
        SPQ_FAULTED = 3'b100
    } spq_state_t;
endpackage
`default_nettype wire

// File: common/spq_sync_if.sv
// bundle of raw pins and their synchronised copies
`default_nettype none
interface spq_sync_if;
    logic [spq_pkg::SYNC_W-1:0] raw;
    logic [spq_pkg::SYNC_W-1:0] clean;
    modport user   (output raw, input clean);
    modport syncer (input raw, output clean);
endinterface
`default_nettype wire

// File: core/spq_sync.sv
// two flip-flop synchroniser for the asynchronous control pins
`default_nettype none
module spq_sync (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    spq_sync_if.syncer  link
);
    logic [spq_pkg::SYNC_W-1:0] stage1;
    logic [spq_pkg::SYNC_W-1:0] stage2;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
        end
        else
        begin
            stage1 <= link.raw;
            stage2 <= stage1;
        end
    end

    assign link.clean = stage2;
endmodule
`default_nettype wire

// File: core/spq_sequencer.sv
// stepper phase sequencer: step edges, direction, enable, fault latches, apb
//
// Operation
// R1: controller pulses step clock per step
// R2: edge select 1: step on rising edge only
// R3: edge select 0: step on both edges
// R4: direction 0 clockwise, 1 counterclockwise
// R5: direction stable 7us around step edges
// R6: mode selects stable 7us around edges
// R7: step clock at most 20/50 kHz
// R8: pulse widths at least 20/10 us
// R9: both-edge duty between 40 and 50 percent
// R10: enable low forces all drives off
// R11: enable low freezes state, ignores inputs
// R12: controller slows steps before stopping
// R13: power-on and pin reset both initialise
// R14: wait 10us after reset before stepping
// R15: open-drain any-fault flag low on fault
// R16: fault type shown as three levels
// R17: faults latch and turn drives off
// R18: only reset clears a latched fault
// R19: monitor output toggles with phase progress
// R20: latched fault blocks stepping and drives
// R21: mode picks step size, phase kept
`default_nettype none
module spq_sequencer (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        stepClock,
    input  wire logic        rotation_direction_select,
    input  wire logic        enable,
    input  wire logic        excitation_select_a,
    input  wire logic        excitation_select_b,
    input  wire logic        clock_edge_select,
    input  wire logic        system_reset_n,
    input  wire logic        openTerminalDetect,
    input  wire logic        overCurrentDetect,
    input  wire logic        overHeatDetect,
    output logic [3:0]       phaseDrive,
    output logic             any_fault_flag_n_out,
    output logic             any_fault_flag_n_oe,
    output logic [1:0]       fault_type_level,
    output logic             excitation_monitor_out,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    spq_sync_if pins ();

    assign pins.raw = {overHeatDetect, overCurrentDetect, openTerminalDetect,
                       system_reset_n, clock_edge_select, excitation_select_b,
                       excitation_select_a, enable, rotation_direction_select,
                       stepClock};

    spq_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .link    (pins.syncer)
    );

    logic stepSync;
    logic dirSync;
    logic enSync;
    logic modeASync;
    logic modeBSync;
    logic edgeSync;
    logic resetNSync;
    logic openSync;
    logic overCurSync;
    logic overHeatSync;

    assign stepSync     = pins.clean[spq_pkg::PIN_STEP_CLK];
    assign dirSync      = pins.clean[spq_pkg::PIN_DIR];
    assign enSync       = pins.clean[spq_pkg::PIN_ENABLE];
    assign modeASync    = pins.clean[spq_pkg::PIN_MODE_A];
    assign modeBSync    = pins.clean[spq_pkg::PIN_MODE_B];
    assign edgeSync     = pins.clean[spq_pkg::PIN_EDGE_SEL];
    assign resetNSync   = pins.clean[spq_pkg::PIN_RESET_N];
    assign openSync     = pins.clean[spq_pkg::PIN_OPEN_TERM];
    assign overCurSync  = pins.clean[spq_pkg::PIN_OVER_CUR];
    assign overHeatSync = pins.clean[spq_pkg::PIN_OVER_HEAT];

    // ------------------------------------------------------------
    // system reset
    // ------------------------------------------------------------
    logic coreRst;

    // either the power-on reset or the reset pin clears the core
    assign coreRst = sys_rst | ~resetNSync; // R13 R18

    // ------------------------------------------------------------
    // step edge detection
    // ------------------------------------------------------------
    logic stepPrev;
    logic stepRise;
    logic stepFall;
    logic anyFault;
    logic stepFire;

    // tracked even while disabled so a level change then is no step later
    always_ff @(posedge clk)
    begin
        if (coreRst)
            stepPrev <= 1'b0;
        else
            stepPrev <= stepSync;
    end

    assign stepRise = stepSync & ~stepPrev;
    assign stepFall = ~stepSync & stepPrev;
    assign stepFire = enSync & ~anyFault & // R11 R20
                      (stepRise | (stepFall & ~edgeSync)); // R2 R3

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    spq_pkg::spq_state_t state;
    spq_pkg::spq_state_t next_state;

    always_comb
    begin
        if (anyFault)
            next_state = spq_pkg::SPQ_FAULTED;
        else if (!enSync)
            next_state = spq_pkg::SPQ_HOLD;
        else
            next_state = spq_pkg::SPQ_RUN;
    end

    always_ff @(posedge clk)
    begin
        if (coreRst)
            state <= spq_pkg::SPQ_HOLD;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // phase position
    // ------------------------------------------------------------
    logic [4:0] pos;
    logic [4:0] stepSize;
    logic [4:0] next_pos;

    // step size per mode; position is never realigned on a mode change
    always_comb
    begin
        unique case ({modeBSync, modeASync}) // R21
            2'b00: stepSize = spq_pkg::INC_TWO_PHASE;
            2'b01: stepSize = spq_pkg::INC_ONE_TWO;
            2'b10: stepSize = spq_pkg::INC_W_ONE_TWO;
            2'b11: stepSize = spq_pkg::INC_2W_ONE_TWO;
        endcase
    end

    always_comb
    begin
        if (dirSync)
            next_pos = pos - stepSize; // R4
        else
            next_pos = pos + stepSize; // R4
    end

    always_ff @(posedge clk)
    begin
        if (coreRst)
            pos <= spq_pkg::POS_RESET;
        else if (stepFire)
            pos <= next_pos;
    end

    // ------------------------------------------------------------
    // fault latches
    // ------------------------------------------------------------
    logic faultOpen;
    logic faultOverCur;
    logic faultOverHeat;

    // sticky until reset, whatever the detector does afterwards
    always_ff @(posedge clk)
    begin
        if (coreRst)
        begin
            faultOpen     <= 1'b0;
            faultOverCur  <= 1'b0;
            faultOverHeat <= 1'b0;
        end
        else
        begin
            faultOpen     <= faultOpen | openSync; // R17
            faultOverCur  <= faultOverCur | overCurSync; // R17
            faultOverHeat <= faultOverHeat | overHeatSync; // R17
        end
    end

    assign anyFault = faultOpen | faultOverCur | faultOverHeat;

    // first fault decides the type; simultaneous ones by priority
    always_ff @(posedge clk)
    begin
        if (coreRst)
            fault_type_level <= spq_pkg::FTYPE_NONE;
        else if (fault_type_level == spq_pkg::FTYPE_NONE)
        begin
            if (openSync)
                fault_type_level <= spq_pkg::FTYPE_OPEN; // R16
            else if (overCurSync)
                fault_type_level <= spq_pkg::FTYPE_OVERCUR; // R16
            else if (overHeatSync)
                fault_type_level <= spq_pkg::FTYPE_OVERHEAT; // R16
        end
    end

    // open drain: only ever pulls low
    assign any_fault_flag_n_out = 1'b0;
    assign any_fault_flag_n_oe  = anyFault; // R15

    // ------------------------------------------------------------
    // drive outputs and monitor
    // ------------------------------------------------------------
    logic       ctrlInhibit;
    logic [3:0] pattern;

    // drive bits {bb, b, ab, a} by half-step sector
    always_comb
    begin
        unique case (pos[4:2])
            3'h0: pattern = 4'h1;
            3'h1: pattern = 4'h5;
            3'h2: pattern = 4'h4;
            3'h3: pattern = 4'h6;
            3'h4: pattern = 4'h2;
            3'h5: pattern = 4'hA;
            3'h6: pattern = 4'h8;
            3'h7: pattern = 4'h9;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (coreRst)
            phaseDrive <= spq_pkg::DRIVE_OFF;
        else if (!enSync || anyFault || ctrlInhibit) // R10 R17 R20
            phaseDrive <= spq_pkg::DRIVE_OFF;
        else
            phaseDrive <= pattern;
    end

    // toggles once per half turn of the table, so rate follows the mode
    always_ff @(posedge clk)
    begin
        if (coreRst)
            excitation_monitor_out <= spq_pkg::POS_RESET[4];
        else
            excitation_monitor_out <= pos[4]; // R19
    end

    // ------------------------------------------------------------
    // settle timer after reset and step counter
    // ------------------------------------------------------------
    logic [spq_pkg::SETTLE_W-1:0] settleCnt;
    logic                         settled;
    logic [15:0]                  stepCount;
    logic                         cntClear;

    // shows software when the far side may start stepping
    always_ff @(posedge clk)
    begin
        if (coreRst)
            settleCnt <= '0;
        else if (!settled)
            settleCnt <= settleCnt + 1'b1;
    end

    assign settled = (settleCnt == spq_pkg::SETTLE_W'(spq_pkg::RST_SETTLE_CYC - 1)); // R14

    // a step in the clear cycle still counts
    always_ff @(posedge clk)
    begin
        if (coreRst)
            stepCount <= spq_pkg::STEPCNT_RESET;
        else if (cntClear)
            stepCount <= {15'h0000, stepFire};
        else if (stepFire)
            stepCount <= stepCount + 16'h0001;
    end

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    logic mapped;
    logic wrAccess;
    logic rdSetup;

    assign mapped   = (paddr == spq_pkg::REG_CTRL) || (paddr == spq_pkg::REG_STATUS) ||
                      (paddr == spq_pkg::REG_STEPCNT);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign wrAccess = psel & penable & pwrite & mapped;
    assign rdSetup  = psel & ~penable & ~pwrite;
    assign cntClear = wrAccess && (paddr == spq_pkg::REG_CTRL) &&
                      pwdata[spq_pkg::CTRL_CNTCLR_BIT];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ctrlInhibit <= spq_pkg::CTRL_INHIBIT_RESET;
        else if (wrAccess && (paddr == spq_pkg::REG_CTRL))
            ctrlInhibit <= pwdata[spq_pkg::CTRL_INHIBIT_BIT];
    end

    // read data is captured in the setup cycle, valid through the access
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prdata <= 32'h00000000;
        else if (rdSetup)
        begin
            unique case (paddr)
                spq_pkg::REG_CTRL:    prdata <= {31'h00000000, ctrlInhibit};
                spq_pkg::REG_STATUS:  prdata <= {13'h0000, state, settled,
                                                 excitation_monitor_out, enSync,
                                                 fault_type_level, faultOverHeat,
                                                 faultOverCur, faultOpen, 3'h0, pos};
                spq_pkg::REG_STEPCNT: prdata <= {16'h0000, stepCount};
                default:              prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    disabled_drive_off_a: assert property ( // R10
        @(posedge clk) disable iff (coreRst)
        !enSync |=> phaseDrive == spq_pkg::DRIVE_OFF)
        else $error("drives active while disabled");

    disabled_freeze_a: assert property ( // R11
        @(posedge clk) disable iff (coreRst)
        (!enSync && $past(!enSync)) |=> pos == $past(pos))
        else $error("position moved while disabled");

    rise_step_a: assert property ( // R2
        @(posedge clk) disable iff (coreRst)
        (enSync && !anyFault && stepRise && !dirSync)
        |=> pos == 5'($past(pos) + $past(stepSize)))
        else $error("rising edge did not advance clockwise");

    reverse_step_a: assert property ( // R4
        @(posedge clk) disable iff (coreRst)
        (enSync && !anyFault && stepRise && dirSync)
        |=> pos == 5'($past(pos) - $past(stepSize)))
        else $error("counterclockwise step wrong");

    fall_ignored_a: assert property ( // R2
        @(posedge clk) disable iff (coreRst)
        (edgeSync && stepFall) |=> $stable(pos))
        else $error("falling edge stepped in rising-only mode");

    fall_step_a: assert property ( // R3
        @(posedge clk) disable iff (coreRst)
        (!edgeSync && stepFall && enSync && !anyFault) |=> !$stable(pos))
        else $error("falling edge missed in both-edge mode");

    fault_sticky_a: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        (anyFault && resetNSync) |=> anyFault)
        else $error("fault latch dropped without reset");

    fault_blocks_a: assert property ( // R20
        @(posedge clk) disable iff (coreRst)
        anyFault |=> (phaseDrive == spq_pkg::DRIVE_OFF) && $stable(pos))
        else $error("drive or step during fault");

    flag_pull_a: assert property ( // R15
        @(posedge clk) disable iff (coreRst)
        $rose(anyFault) |-> any_fault_flag_n_oe && !any_fault_flag_n_out
                            && (fault_type_level != spq_pkg::FTYPE_NONE))
        else $error("fault flag or type not shown");

    type_open_a: assert property ( // R16
        @(posedge clk) disable iff (coreRst)
        (openSync && fault_type_level == spq_pkg::FTYPE_NONE)
        |=> fault_type_level == spq_pkg::FTYPE_OPEN)
        else $error("open terminal type not reported");

    reset_clear_a: assert property ( // R18
        @(posedge clk)
        coreRst |=> !anyFault && (fault_type_level == spq_pkg::FTYPE_NONE))
        else $error("reset did not clear faults");

    monitor_track_a: assert property ( // R19
        @(posedge clk) disable iff (coreRst)
        ##1 excitation_monitor_out == $past(pos[4]))
        else $error("monitor does not follow phase");
endmodule
`default_nettype wire

// File: bench/spq_step_source.sv
// controller model: bursts of step clock pulses with guard time and slow-down
`default_nettype none
module spq_step_source #(
    parameter int HALF_CYC  = 1000,
    parameter int GUARD_CYC = 700
) (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [2:0] count,
    output logic            stepClock,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        stepClock = 1'b0;
        busy      = 1'b0;
    end

    // each pulse is one step request under rising-edge select, two under both edges; high and low halves are equal except the last low half, which is doubled
    always
    begin
        @(posedge clk);
        if (start)
        begin
            busy <= 1'b1;
            // selects and direction only move while the model is idle
            repeat (GUARD_CYC) @(posedge clk);
            for (int i = 0; i < count; i++)
            begin
                stepClock <= 1'b1;
                repeat (HALF_CYC) @(posedge clk);
                stepClock <= 1'b0;
                // last pulse stretched so the shaft does not overrun
                repeat ((i == count - 1) ? 2 * HALF_CYC : HALF_CYC) @(posedge clk);
            end
            repeat (GUARD_CYC) @(posedge clk);
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: bench/stepper_phase_sequencer_bench.sv
// self-checking bench of the stepper phase sequencer
`default_nettype none
module stepper_phase_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, sysRst, stepClock, dirSel, enable, modeA, modeB, edgeSel;
    logic        pinResetN, flagOut, flagOe, monitor, psel, penable, pwrite;
    logic        pready, pslverr, start, busy, rerr;
    logic [2:0]  det, count, n;
    logic [3:0]  phaseDrive;
    logic [1:0]  faultType, m;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata, r;
    logic [31:0] seed = 32'h0000_0006;
    logic [4:0]  expPos;
    int          n_errors = 0;
    int          comparisons = 0;
    int          stepsNow, stepTotal = 0;

    always #5 clk = ~clk;

    // pin rules are microseconds; halves shortened to keep the run short
    spq_step_source #(.HALF_CYC(40), .GUARD_CYC(8)) src_u (
        .clk(clk), .start(start), .count(count), .stepClock(stepClock), .busy(busy));

    spq_sequencer dut_u (
        .clk(clk), .sys_rst(sysRst), .stepClock(stepClock),
        .rotation_direction_select(dirSel), .enable(enable),
        .excitation_select_a(modeA), .excitation_select_b(modeB),
        .clock_edge_select(edgeSel), .system_reset_n(pinResetN),
        .openTerminalDetect(det[0]), .overCurrentDetect(det[1]),
        .overHeatDetect(det[2]), .phaseDrive(phaseDrive),
        .any_fault_flag_n_out(flagOut), .any_fault_flag_n_oe(flagOe),
        .fault_type_level(faultType), .excitation_monitor_out(monitor),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [4:0] advance(logic [4:0] p, logic [1:0] md, logic d, int s);
        int inc;
        inc = 8 >> md;
        return d ? 5'(int'(p) - inc * s) : 5'(int'(p) + inc * s);
    endfunction

    function automatic logic [3:0] drv(logic [4:0] p);
        logic [3:0] tbl [8] = '{4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9};
        return tbl[p[4:2]];
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic burst(input logic [2:0] k);
        @(posedge clk);
        count <= k;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        do
            @(posedge clk);
        while (busy !== 1'b0);
        repeat (2) @(posedge clk);
    endtask

    task automatic checkPos();
        apb(1'b0, 8'h04, 32'h0);
        check(32'(rdata[4:0]), 32'(expPos));
        check(32'(phaseDrive), 32'(drv(expPos)));
        check(32'(monitor), 32'(expPos[4]));
        check(32'(rdata[18:16]), 32'h1);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        summarize();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {clk, dirSel, modeA, modeB, psel, penable, pwrite, start} = 8'h00;
        {sysRst, enable, edgeSel, pinResetN} = 4'hF;
        det = 3'h0;
        count = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        repeat (1000) @(posedge clk);
        expPos = 5'h04;
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h0);
        checkPos();
        // every mode under both edge selects, then random modes
        for (int i = 0; i < 12; i++)
        begin
            r = rnd();
            m = (i < 8) ? 2'(i >> 1) : r[1:0];
            n = 3'(1 + r[4:3]);
            @(posedge clk);
            edgeSel <= i[0];
            dirSel <= r[2];
            {modeB, modeA} <= m;
            burst(n);
            stepsNow = i[0] ? int'(n) : 2 * int'(n);
            stepTotal += stepsNow;
            expPos = advance(expPos, m, r[2], stepsNow);
            checkPos();
        end
        // step counter against the steps issued, then its clear pulse
        apb(1'b0, 8'h08, 32'h0);
        check(rdata, 32'(stepTotal));
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        check(rdata, 32'h0);
        @(posedge clk);
        enable <= 1'b0;
        repeat (6) @(posedge clk);
        check(32'(phaseDrive), 32'h0);
        burst(3'h3);
        enable <= 1'b1;
        repeat (6) @(posedge clk);
        checkPos();
        // inhibit readback and an unmapped place
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h1);
        check(32'(phaseDrive), 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check(32'(rerr), 32'h1);
        check(rdata, 32'h0);
        // one detector at a time, cleared only by the reset pin
        for (int f = 0; f < 3; f++)
        begin
            @(posedge clk);
            det <= 3'(1 << f);
            repeat (6) @(posedge clk);
            check(32'(flagOe), 32'h1);
            check(32'(flagOut), 32'h0);
            check(32'(faultType), 32'(f + 1));
            check(32'(phaseDrive), 32'h0);
            det <= 3'h0;
            burst(3'h2);
            check(32'(flagOe), 32'h1);
            check(32'(phaseDrive), 32'h0);
            apb(1'b0, 8'h04, 32'h0);
            check(32'(rdata[4:0]), 32'(expPos));
            check(32'(rdata[10:8]), 32'(1 << f));
            check(32'(rdata[18:16]), 32'h4);
            pinResetN <= 1'b0;
            repeat (4) @(posedge clk);
            pinResetN <= 1'b1;
            repeat (1000) @(posedge clk);
            expPos = 5'h04;
            check(32'(flagOe), 32'h0);
            check(32'(faultType), 32'h0);
            checkPos();
        end
        summarize();
    end
endmodule
`default_nettype wire
